//--- logic/autoneg_page_registers.sv
/*
 Next page and expansion register bank behind a Wishbone slave.
 Assumes link-side strobes are one-cycle pulses, inputs synchronous.
*/
// The Wishbone slave port is this design's own decision.
// Notes on behaviour
// - Reserved bits ignore writes and read zero.
// - Bit 4 follows the parallel detect fault.
// - Bit 3 shows partner next page support.
// - Bit 2 always reads one, never written.
// - Page flag sets on word, clears on read.
// - Bit 0 shows partner autoneg support.
// - Bit 15 asks for more pages, sent out.
// - Bit 13 selects message or unformatted page.
// - Bit 12 comply flag written, then sent.
// - Toggle is inverse of previous word's toggle.
// - Code field resets to null message one.
// - Partner bit 12 shows comply ability.
// - Partner bit 11 shows partner toggle.
// - Partner code captured, reset to zero.
// - Partner bit 15 shows more pages wanted.
`timescale 1ns/1ps
module autoneg_page_registers
  import autoneg_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Negotiation logic status.
  input wire logic parallel_detect_fault,
  input wire logic partner_next_page_support,
  input wire logic partner_autoneg_support,
  // Received and transmitted pages.
  input wire logic page_rx_strobe,
  input wire logic [15:0] page_rx_word,
  input wire logic tx_word_request,
  output logic [15:0] tx_word,
  output logic tx_word_valid,
  // Interrupt.
  output logic irq
);

  // ****************************************************************
  // Byte lane merge
  // ****************************************************************

  // Merges a write into a 16-bit value by the two low byte enables.
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] sel
  );
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = data[7:0];
    end
    if (sel[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // ****************************************************************
  // Storage
  // ****************************************************************

  bus_state_t state; // Bus answer state.
  bus_state_t next_state; // Next bus answer state.
  logic more_pages_flag; // Request for a further next page.
  logic message_page_select; // Message versus unformatted.
  logic comply_ability_flag; // Local will comply.
  logic [CODE_W-1:0] tx_code; // Outgoing code field.
  logic page_received; // Sticky page flag, clear on read.
  logic fault_q; // Last fault level, for edge detect.
  logic [IRQ_W-1:0] irq_status; // Sticky interrupt events.
  logic [IRQ_W-1:0] irq_enable; // Interrupt enables.

  np_link_if link();

  np_word_tracker u_tracker (
    .clk(clk),
    .reset(reset),
    .link(link)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************

  wire [5:0] idx = wb_adr_i[7:2];
  // A request is taken only in idle, on the edge where ack rises.
  wire take = wb_cyc_i && wb_stb_i && (state == BUS_IDLE);
  wire wr = take && wb_we_i;
  wire rd = take && !wb_we_i;
  wire wr_nptx = wr && (idx == IDX_NPTX);
  wire wr_clear = wr && (idx == IDX_IRQ_CLEAR);
  wire wr_enable = wr && (idx == IDX_IRQ_ENABLE);
  wire rd_exp = rd && (idx == IDX_EXP);
  wire transmit_toggle_bit = link.tx_toggle;

  // Expansion value; upper bits are constant zero.
  wire [15:0] exp_value = {11'h000,
    parallel_detect_fault,
    partner_next_page_support,
    1'b1,
    page_received,
    partner_autoneg_support};

  // Transmit register view; bit 14 is held at zero.
  wire [15:0] nptx_value = {more_pages_flag, 1'b0,
    message_page_select, comply_ability_flag,
    transmit_toggle_bit, tx_code};

  // Read mux; unmapped indices read as zero.
  wire [15:0] rd_value =
    (idx == IDX_EXP) ? exp_value :
    (idx == IDX_NPTX) ? nptx_value :
    (idx == IDX_PARTNER) ? link.partner :
    (idx == IDX_IRQ_STATUS) ? {13'h0, irq_status} :
    (idx == IDX_IRQ_ENABLE) ? {13'h0, irq_enable} :
    16'h0000;

  // Merged write for the transmit register.
  wire [15:0] nptx_wr = merge16(nptx_value, wb_dat_i, wb_sel_i);
  // Merged write for the enable register.
  wire [15:0] en_wr = merge16({13'h0, irq_enable},
    wb_dat_i, wb_sel_i);
  // Merged write-one-to-clear mask.
  wire [15:0] clr_wr = merge16(16'h0000, wb_dat_i, wb_sel_i);

  // Interrupt events this cycle.
  wire [IRQ_W-1:0] irq_event = {tx_word_request,
    parallel_detect_fault && !fault_q, page_rx_strobe};
  wire [IRQ_W-1:0] irq_clr = wr_clear ? clr_wr[IRQ_W-1:0] :
    {IRQ_W{1'b0}};
  // Set wins over a clear in the same cycle.
  wire [IRQ_W-1:0] next_irq_status =
    (irq_status & ~irq_clr) | irq_event;
  wire [IRQ_W-1:0] next_irq_enable = wr_enable ?
    en_wr[IRQ_W-1:0] : irq_enable;

  // A word arriving during the clearing read is kept.
  wire next_page_received = page_rx_strobe ||
    (page_received && !rd_exp);

  assign next_state = take ? BUS_ACK : BUS_IDLE;

  // Feed the tracker.
  assign link.rx_strobe = page_rx_strobe;
  assign link.rx_word = page_rx_word;
  assign link.tx_request = tx_word_request;
  assign link.tx_fields = nptx_value;

  // ****************************************************************
  // Bus answer
  // ****************************************************************

  // Ack comes one cycle after the request, then drops for one cycle,
  // so a request dropped once ack is sampled is taken only once; one held longer is taken again.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      state <= next_state;
      wb_ack_o <= take;
      if (rd) begin
        wb_dat_o <= {16'h0000, rd_value};
      end
    end
  end

  // ****************************************************************
  // Transmit next page register
  // ****************************************************************

  // Software fields; the toggle and bit 14 are not writable.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      more_pages_flag <= 1'b0;
      message_page_select <= MP_RESET;
      comply_ability_flag <= 1'b0;
      tx_code <= CODE_RESET;
    end else if (wr_nptx) begin
      more_pages_flag <= nptx_wr[NP_MORE];
      message_page_select <= nptx_wr[NP_MP];
      comply_ability_flag <= nptx_wr[NP_COMPLY_ABILITY_FLAG];
      tx_code <= nptx_wr[CODE_W-1:0];
    end
  end

  // ****************************************************************
  // Status flags and interrupt
  // ****************************************************************

  // Page flag, fault history and interrupt state.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      page_received <= 1'b0;
      fault_q <= 1'b0;
      irq_status <= {IRQ_W{1'b0}};
      irq_enable <= {IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      page_received <= next_page_received;
      fault_q <= parallel_detect_fault;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      irq <= |(next_irq_status & next_irq_enable);
    end
  end

  // Outgoing word comes from tracker flip-flops.
  assign tx_word = link.tx_word;
  assign tx_word_valid = link.tx_valid;

  // ****************************************************************
  // Checks
  // ****************************************************************

  property p_exp_reserved;
    @(posedge clk) disable iff (reset)
      rd_exp |=> wb_ack_o && wb_dat_o[31:5] == 27'h0;
  endproperty
  a_exp_reserved: assert property (p_exp_reserved)
    else $error("expansion reserved bits not zero");

  property p_exp_fault;
    @(posedge clk) disable iff (reset)
      rd_exp |=> wb_dat_o[EXP_FAULT] == $past(parallel_detect_fault);
  endproperty
  a_exp_fault: assert property (p_exp_fault)
    else $error("fault bit wrong");

  property p_exp_abilities;
    @(posedge clk) disable iff (reset)
      rd_exp |=> wb_dat_o[EXP_LP_NP] == $past(partner_next_page_support)
        && wb_dat_o[EXP_LP_AN] == $past(partner_autoneg_support);
  endproperty
  a_exp_abilities: assert property (p_exp_abilities)
    else $error("partner ability bits wrong");

  property p_exp_local_next_page_support;
    @(posedge clk) disable iff (reset)
      rd_exp |=> wb_dat_o[EXP_NP];
  endproperty
  a_exp_local_next_page_support: assert property (p_exp_local_next_page_support)
    else $error("local next page bit not one");

  property p_page_set;
    @(posedge clk) disable iff (reset)
      page_rx_strobe |=> page_received;
  endproperty
  a_page_set: assert property (p_page_set)
    else $error("page flag not set");

  property p_page_cor;
    @(posedge clk) disable iff (reset)
      rd_exp && !page_rx_strobe |=> !page_received;
  endproperty
  a_page_cor: assert property (p_page_cor)
    else $error("page flag not cleared by read");

  property p_tx_fields;
    @(posedge clk) disable iff (reset)
      tx_word_request |=> tx_word_valid
        && tx_word[NP_MORE] == $past(more_pages_flag)
        && tx_word[NP_COMPLY_ABILITY_FLAG] == $past(comply_ability_flag)
        && tx_word[NP_MP] == $past(message_page_select);
  endproperty
  a_tx_fields: assert property (p_tx_fields)
    else $error("outgoing word fields wrong");

  property p_code_reset;
    @(posedge clk) disable iff (reset)
      $past(reset) |-> tx_code == CODE_RESET && message_page_select;
  endproperty
  a_code_reset: assert property (p_code_reset)
    else $error("transmit register reset value wrong");

  property p_partner_read;
    @(posedge clk) disable iff (reset)
      rd && idx == IDX_PARTNER |=>
        wb_dat_o[15:0] == $past(link.partner);
  endproperty
  a_partner_read: assert property (p_partner_read)
    else $error("partner register read wrong");

  property p_irq_level;
    @(posedge clk) disable iff (reset)
      irq == |(irq_status & irq_enable);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level mismatch");

  property p_ack_pulse;
    @(posedge clk) disable iff (reset)
      take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack not a one-cycle pulse");

  property p_nptx_reserved;
    @(posedge clk) disable iff (reset)
      rd && idx == IDX_NPTX |=>
        wb_dat_o[NP_MORE-1] == 1'b0 && wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_nptx_reserved: assert property (p_nptx_reserved)
    else $error("transmit reserved bit not zero");

  property p_nptx_read;
    @(posedge clk) disable iff (reset)
      rd && idx == IDX_NPTX |=>
        wb_dat_o[NP_TOG] == $past(link.tx_toggle)
        && wb_dat_o[CODE_W-1:0] == $past(tx_code);
  endproperty
  a_nptx_read: assert property (p_nptx_read)
    else $error("transmit register read wrong");

  property p_fault_event;
    @(posedge clk) disable iff (reset)
      parallel_detect_fault && !fault_q |=> irq_status[IRQ_FAULT];
  endproperty
  a_fault_event: assert property (p_fault_event)
    else $error("fault event not latched");

  property p_page_event;
    @(posedge clk) disable iff (reset)
      page_rx_strobe |=> irq_status[IRQ_PAGE];
  endproperty
  a_page_event: assert property (p_page_event)
    else $error("page event not latched");

  property p_valid_pulse;
    @(posedge clk) disable iff (reset)
      !tx_word_request |=> !tx_word_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("outgoing word strobe without request");
endmodule : autoneg_page_registers

//--- logic/autoneg_pkg.sv
/*
 Constants for the next page register bank: indices, fields, resets.
 Assumes a Wishbone slave with 32-bit data and word indices.
*/
package autoneg_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [5:0] IDX_EXP = 6'h06;
  localparam logic [5:0] IDX_NPTX = 6'h07;
  localparam logic [5:0] IDX_PARTNER = 6'h08;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h11;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h12;
  // Next page word field positions.
  localparam int NP_MORE = 15;
  localparam int NP_MP = 13;
  localparam int NP_COMPLY_ABILITY_FLAG = 12;
  localparam int NP_TOG = 11;
  localparam int CODE_W = 11;
  // Expansion register field positions.
  localparam int EXP_FAULT = 4;
  localparam int EXP_LP_NP = 3;
  localparam int EXP_NP = 2;
  localparam int EXP_PAGE = 1;
  localparam int EXP_LP_AN = 0;
  // Reset values.
  localparam logic [CODE_W-1:0] CODE_RESET = 11'h001;
  localparam logic MP_RESET = 1'b1;
  // Interrupt event bits.
  localparam int IRQ_W = 3;
  localparam int IRQ_PAGE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_SENT = 2;
  // Bus answer states, Gray order.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_t;
endpackage : autoneg_pkg

//--- logic/np_link_if.sv
/*
 Carrier between the register bank and the next page word tracker.
 Assumes both ends run on the one device clock.
*/
`timescale 1ns/1ps
interface np_link_if;
  logic rx_strobe;        // A partner word arrived.
  logic [15:0] rx_word;   // The partner word.
  logic tx_request;       // Link logic wants the next outgoing word.
  logic [15:0] tx_fields; // Software fields of the outgoing word.
  logic [15:0] tx_word;   // Formed outgoing word.
  logic tx_valid;         // Outgoing word strobe.
  logic [15:0] partner;   // Latched partner word.
  logic tx_toggle;        // Toggle for the next outgoing word.
  modport regs (output rx_strobe, rx_word, tx_request, tx_fields,
    input tx_word, tx_valid, partner, tx_toggle);
  modport tracker (input rx_strobe, rx_word, tx_request, tx_fields,
    output tx_word, tx_valid, partner, tx_toggle);
endinterface : np_link_if

//--- logic/np_word_tracker.sv
/*
 Latches the partner next page word and forms outgoing words.
 Assumes strobes are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ps
module np_word_tracker
  import autoneg_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Link to the register bank.
  np_link_if.tracker link
);
  logic [15:0] partner;
  logic toggle;
  logic [15:0] word;
  logic valid;
  assign link.partner = partner;
  assign link.tx_toggle = toggle;
  assign link.tx_word = word;
  assign link.tx_valid = valid;

  // Capture partner words; form and send outgoing words.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      partner <= 16'h0000;
      toggle <= 1'b0;
      word <= 16'h0000;
      valid <= 1'b0;
    end else begin
      valid <= link.tx_request;
      if (link.rx_strobe) begin
        partner <= link.rx_word;
      end
      if (link.tx_request) begin
        word <= {link.tx_fields[15:12], toggle,
          link.tx_fields[CODE_W-1:0]};
        toggle <= ~toggle;
      end
    end
  end

  property p_toggle_flip;
    @(posedge clk) disable iff (reset)
      link.tx_request |=> link.tx_toggle != word[NP_TOG];
  endproperty
  a_toggle_flip: assert property (p_toggle_flip)
    else $error("toggle not inverted after send");

  property p_partner_capture;
    @(posedge clk) disable iff (reset)
      link.rx_strobe |=> partner == $past(link.rx_word);
  endproperty
  a_partner_capture: assert property (p_partner_capture)
    else $error("partner word not captured");
endmodule : np_word_tracker

//--- verification/link_partner_model.sv
/*
 Model of the partner negotiation logic: pages in, word requests, status.
 Assumes the bench calls its tasks from one sequence, clocked by clk.
*/
`timescale 1ns/1ps
module link_partner_model (
  // Clock.
  input wire logic clk,
  // Lines toward the register bank.
  output logic page_rx_strobe,
  output logic [15:0] page_rx_word,
  output logic tx_word_request,
  output logic fault_level,
  output logic pages_able,
  output logic autoneg_able
);
  // Idle lines start quiet; the word shows a pattern, not a held value.
  initial begin
    page_rx_strobe = 1'b0;
    page_rx_word = 16'h5a5a;
    tx_word_request = 1'b0;
    fault_level = 1'b0;
    pages_able = 1'b0;
    autoneg_able = 1'b0;
  end
  // One received word: a single strobe, then the word is scrambled.
  task automatic send_page(input logic [15:0] w);
    @(posedge clk);
    page_rx_strobe <= 1'b1;
    page_rx_word <= w;
    @(posedge clk);
    page_rx_strobe <= 1'b0;
    page_rx_word <= ~w;
  endtask : send_page
  // Ask for n outgoing words back to back.
  task automatic request(input int n);
    @(posedge clk);
    tx_word_request <= 1'b1;
    repeat (n) @(posedge clk);
    tx_word_request <= 1'b0;
  endtask : request
endmodule : link_partner_model

//--- verification/autoneg_page_registers_test.sv
/*
 Self-checking bench for the next page register bank.
 Assumes a classic Wishbone master and the partner model beside it.
*/
`timescale 1ns/1ps
module autoneg_page_registers_test;
  import autoneg_pkg::*;
  logic clk, reset, cyc, stb, we, ack, valid, irq, req, strobe;
  logic fault, pages, an;
  logic [7:0] adr;
  logic [31:0] dat, rdat;
  logic [15:0] rx_word, tx_word, q;
  logic [15:0] sent [$];
  int err_count, n_tests, cycles;
  // Clock of 40 ns.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  autoneg_page_registers u_dut (.clk(clk), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .parallel_detect_fault(fault), .partner_next_page_support(pages),
    .partner_autoneg_support(an), .page_rx_strobe(strobe),
    .page_rx_word(rx_word), .tx_word_request(req), .tx_word(tx_word),
    .tx_word_valid(valid), .irq(irq));
  link_partner_model u_far (.clk(clk), .page_rx_strobe(strobe),
    .page_rx_word(rx_word), .tx_word_request(req), .fault_level(fault),
    .pages_able(pages), .autoneg_able(an));
  // Collect each outgoing word in the cycle its strobe stands.
  always @(posedge clk) begin
    if (valid === 1'b1) sent.push_back(tx_word);
  end
  // A hang is cut short here.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", name, e, g);
      err_count++;
    end
  endtask : chk
  // One classic cycle; the request holds until ack is sampled high.
  task automatic bus(input logic [7:0] a, input logic w,
      input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0000, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus(a, 1'b0, 16'h0000);
    chk("read data", e, q);
  endtask : rd
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", {15'h0, e}, {15'h0, irq});
  endtask : irq_is
  // Main sequence.
  initial begin
    reset = 1'b1;
    {cyc, stb, we} = 3'b000;
    adr = 8'h00;
    dat = 32'h0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(8'h18, 16'h0004);
    rd(8'h1c, 16'h2001);
    rd(8'h20, 16'h0000);
    bus(8'h18, 1'b1, 16'hffff);
    rd(8'h18, 16'h0004);
    bus(8'h1c, 1'b1, 16'hffff);
    rd(8'h1c, 16'hb7ff);
    rd(8'h3c, 16'h0000);
    u_far.fault_level <= 1'b1;
    u_far.pages_able <= 1'b1;
    u_far.autoneg_able <= 1'b1;
    rd(8'h18, 16'h001d);
    u_far.fault_level <= 1'b0;
    u_far.autoneg_able <= 1'b0;
    rd(8'h18, 16'h000c);
    u_far.pages_able <= 1'b0;
    rd(8'h18, 16'h0004);
    rd(8'h40, 16'h0002);
    rd(8'h44, 16'h0000);
    bus(8'h44, 1'b1, 16'h0007);
    bus(8'h48, 1'b1, 16'h0001);
    irq_is(1'b0);
    u_far.send_page(16'h9abc);
    irq_is(1'b1);
    rd(8'h40, 16'h0001);
    rd(8'h18, 16'h0006);
    rd(8'h18, 16'h0004);
    rd(8'h20, 16'h9abc);
    bus(8'h48, 1'b1, 16'h0000);
    irq_is(1'b0);
    bus(8'h48, 1'b1, 16'h0001);
    irq_is(1'b1);
    bus(8'h44, 1'b1, 16'h0001);
    irq_is(1'b0);
    bus(8'h1c, 1'b1, 16'h9155);
    rd(8'h1c, 16'h9155);
    u_far.request(2);
    u_far.request(1);
    repeat (2) @(posedge clk);
    chk("word count", 16'd3, 16'(sent.size()));
    chk("word 0", 16'h9155, sent[0]);
    chk("word 1", 16'h9955, sent[1]);
    chk("word 2", 16'h9155, sent[2]);
    rd(8'h1c, 16'h9955);
    rd(8'h40, 16'h0004);
    report_and_stop();
  end
endmodule : autoneg_page_registers_test
